// >>> pkg/tcc_pkg.sv
/*
 * constants, field layout and types of the two-channel temperature
 * conversion sequencer.
 * assumes a 125 mhz system clock and a 32-bit classic wishbone master.
 */
package tcc_pkg;
    // ==================================================
    // register byte addresses
    localparam logic [7:0] ADDR_CONFIG  = 8'h00;
    localparam logic [7:0] ADDR_RATE    = 8'h04;
    localparam logic [7:0] ADDR_ONESHOT = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;
    localparam logic [7:0] ADDR_LOCAL   = 8'h10;
    localparam logic [7:0] ADDR_REMOTE  = 8'h14;
    localparam logic [7:0] ADDR_LIMIT1  = 8'h18;
    localparam logic [7:0] ADDR_LIMIT2  = 8'h1c;
    // ==================================================
    // fields and reset values
    localparam int         CFG_HALT_BIT   = 6;
    localparam int         CFG_SENSOR_BIT = 5;
    localparam int         STAT_BUSY_BIT  = 0;
    localparam int         STAT_SLEEP_BIT = 1;
    localparam int         RATE_W         = 4;
    localparam logic [3:0] RATE_MAX       = 4'h8;
    localparam logic [3:0] RATE_EXT_MAX   = 4'h6;
    localparam logic [3:0] RATE_RST       = 4'h6;
    localparam int         TEMP_W         = 11;
    localparam int         FRAC_W         = 3;
    localparam int         LIMIT_W        = 8;
    localparam logic [7:0] LIMIT_RST      = 8'h55;
    localparam logic [2:0] FRAC_ZERO      = 3'h0;
    // ==================================================
    // timing
    localparam int CLK_HZ      = 125_000_000;
    localparam int INTEG_MS    = 60;
    localparam int RATE_BASE_S = 16;
    localparam int INTEG_CYC   = (CLK_HZ / 1000) * INTEG_MS;
    localparam int RATE_CYC    = CLK_HZ * RATE_BASE_S;
    // ==================================================
    // types
    typedef struct packed {
        logic remote;
        logic extended;
        logic substrate;
    } tcc_req_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_REQ, SQ_WAIT} tcc_seq_t;
    typedef enum logic {LK_IDLE, LK_BUSY} tcc_lnk_t;
endpackage : tcc_pkg

// >>> hdl/tcc_conv_ctrl.sv
/*
 * conversion sequencer with wishbone registers, converter link on the
 * converter's own clock and two open-drain overtemperature alarms.
 * assumes the converter raises conv_done_in for one adc clock with data.
 */
// Design decisions made here: the placing of the registers and register access over Wishbone.
// Functional notes
// - each alarm asserts above its own limit
// - free-running rate conversions and single-shot conversions
// - extended 10+sign 0.125C for slow, single-shot
// - legacy 7+sign 1C for 8Hz, 16Hz
// - allow 60ms integration per channel, 120ms when extended
// - every sequence converts both local and remote
// - both results appear together after sequence ends
// - halt clear free-runs; one-shot starts full sequence
// - busy flag set only while sequence runs
// - previous results stay readable while converting
// - config bit 5 selects remote sensor type
// - halt bit gives standby, data kept
// - one-shot works in halt, ignored in sleep
// - standby mid-sequence aborts without updating results
module tcc_conv_ctrl #(
    parameter int ADDR_W           = 8,
    parameter int INTEG_CYCLES     = tcc_pkg::INTEG_CYC,
    parameter int RATE_BASE_CYCLES = tcc_pkg::RATE_CYC
) (
    // system
    input  wire logic                        clock_in,
    input  wire logic                        reset_in,
    // wishbone slave
    input  wire logic                        wb_cyc_in,
    input  wire logic                        wb_stb_in,
    input  wire logic                        wb_we_in,
    input  wire logic [ADDR_W-1:0]           wb_adr_in,
    input  wire logic [3:0]                  wb_sel_in,
    input  wire logic [31:0]                 wb_dat_in,
    output logic      [31:0]                 wb_dat_out,
    output logic                             wb_ack_out,
    // converter link
    input  wire logic                        adc_clk_in,
    output logic                             conv_start_out,
    output tcc_pkg::tcc_req_t                conv_req_out,
    input  wire logic                        conv_done_in,
    input  wire logic [tcc_pkg::TEMP_W-1:0]  conv_data_in,
    // pins
    input  wire logic                        hw_sleep_n_in,
    input  wire logic                        overtemp_alarm_first_n_in,
    output logic                             overtemp_alarm_first_n_out,
    output logic                             overtemp_alarm_first_n_oe_out,
    input  wire logic                        overtemp_alarm_second_n_in,
    output logic                             overtemp_alarm_second_n_out,
    output logic                             overtemp_alarm_second_n_oe_out
);
    import tcc_pkg::*;

    localparam logic [31:0] INTEG_N = 32'(INTEG_CYCLES);

    function automatic logic [31:0] rate_period(input logic [3:0] r);
        logic [3:0] n;
        n = (r > RATE_MAX) ? RATE_MAX : r;
        return (32'(RATE_BASE_CYCLES) >> n) - 32'h1;
    endfunction : rate_period

    function automatic logic over_limit(input logic [TEMP_W-1:0] t,
                                        input logic [LIMIT_W-1:0] l);
        return $signed(t[TEMP_W-1:FRAC_W]) > $signed(l);
    endfunction : over_limit

    // ==================================================
    // sleep pin synchroniser
    logic sl1_r, sl2_r;
    always_ff @(posedge clock_in) begin
        sl1_r <= hw_sleep_n_in;
        sl2_r <= sl1_r;
    end
    logic sleep;
    assign sleep = !sl2_r;

    // ==================================================
    // register bus
    logic                wb_req, wb_wr, ack_r, ack_nxt;
    logic [31:0]         dat_r, dat_nxt;
    logic                halt_r, halt_nxt, sens_r, sens_nxt;
    logic [RATE_W-1:0]   rate_r, rate_nxt;
    logic [LIMIT_W-1:0]  lim1_r, lim1_nxt, lim2_r, lim2_nxt;
    logic [TEMP_W-1:0]   loc_r, rem_r;
    logic                one_stb, halt_set;
    tcc_seq_t            seq_r;

    assign wb_req = wb_cyc_in && wb_stb_in && !ack_r;
    assign wb_wr  = wb_req && wb_we_in && wb_sel_in[0];

    always_comb begin
        ack_nxt  = wb_req;
        dat_nxt  = 32'h0;
        halt_nxt = halt_r;
        sens_nxt = sens_r;
        rate_nxt = rate_r;
        lim1_nxt = lim1_r;
        lim2_nxt = lim2_r;
        one_stb  = 1'b0;
        halt_set = 1'b0;
        if (wb_wr) begin
            case (wb_adr_in)
                ADDR_CONFIG: begin
                    halt_nxt = wb_dat_in[CFG_HALT_BIT];
                    halt_set = wb_dat_in[CFG_HALT_BIT];
                    sens_nxt = wb_dat_in[CFG_SENSOR_BIT];
                end
                ADDR_RATE:    rate_nxt = wb_dat_in[RATE_W-1:0];
                ADDR_ONESHOT: one_stb = 1'b1;
                ADDR_LIMIT1:  lim1_nxt = wb_dat_in[LIMIT_W-1:0];
                ADDR_LIMIT2:  lim2_nxt = wb_dat_in[LIMIT_W-1:0];
                default:      one_stb = 1'b0;
            endcase
        end
        if (wb_req && !wb_we_in) begin
            dat_nxt = 32'h0;
            case (wb_adr_in)
                ADDR_CONFIG: begin
                    dat_nxt[CFG_HALT_BIT]   = halt_r;
                    dat_nxt[CFG_SENSOR_BIT] = sens_r;
                end
                ADDR_RATE: dat_nxt[RATE_W-1:0] = rate_r;
                ADDR_STATUS: begin
                    dat_nxt[STAT_BUSY_BIT]  = (seq_r != SQ_IDLE);
                    dat_nxt[STAT_SLEEP_BIT] = sleep;
                end
                ADDR_LOCAL:  dat_nxt[TEMP_W-1:0] = loc_r;
                ADDR_REMOTE: dat_nxt[TEMP_W-1:0] = rem_r;
                ADDR_LIMIT1: dat_nxt[LIMIT_W-1:0] = lim1_r;
                ADDR_LIMIT2: dat_nxt[LIMIT_W-1:0] = lim2_r;
                default:     dat_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ack_r  <= 1'b0;
            dat_r  <= 32'h0;
            halt_r <= 1'b0;
            sens_r <= 1'b0;
            rate_r <= RATE_RST;
            lim1_r <= LIMIT_RST;
            lim2_r <= LIMIT_RST;
        end else begin
            ack_r  <= ack_nxt;
            dat_r  <= dat_nxt;
            halt_r <= halt_nxt;
            sens_r <= sens_nxt;
            rate_r <= rate_nxt;
            lim1_r <= lim1_nxt;
            lim2_r <= lim2_nxt;
        end
    end
    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;

    // ==================================================
    // sequencer
    logic              as1_r, as2_r, as3_r, ack_ev, lak_r, lak_nxt;
    logic [TEMP_W-1:0] lnk_dat_r;
    logic              ch_r, ch_nxt, ext_r, ext_nxt, one_r, one_nxt;
    logic              got_r, got_nxt, pend_r, pend_nxt;
    logic              rtg_r, rtg_nxt;
    logic [31:0]       tmr_r, tmr_nxt, rt_r, rt_nxt;
    logic [TEMP_W-1:0] res_r, res_nxt, lnew_r, lnew_nxt;
    logic [TEMP_W-1:0] loc_nxt, rem_nxt, din;
    tcc_seq_t          seq_nxt;
    tcc_req_t          req_r, req_nxt;
    logic              abort, free_go, one_go;

    assign ack_ev  = as2_r ^ as3_r;
    // legacy results carry whole degrees only
    assign din     = ext_r ? lnk_dat_r : {lnk_dat_r[TEMP_W-1:FRAC_W], FRAC_ZERO};
    assign abort   = sleep || halt_set || (halt_r && !one_r);
    assign free_go = !halt_r && !sleep && (rt_r == 32'h0);
    assign one_go  = one_stb && !sleep;

    always_comb begin
        seq_nxt  = seq_r;
        ch_nxt   = ch_r;
        ext_nxt  = ext_r;
        one_nxt  = one_r;
        got_nxt  = got_r;
        pend_nxt = pend_r && !ack_ev;
        rtg_nxt  = rtg_r;
        tmr_nxt  = tmr_r;
        res_nxt  = (ack_ev && pend_r) ? din : res_r;
        lnew_nxt = lnew_r;
        loc_nxt  = loc_r;
        rem_nxt  = rem_r;
        req_nxt  = req_r;
        rt_nxt   = (rt_r == 32'h0) ? rt_r : rt_r - 32'h1;
        case (seq_r)
            SQ_IDLE: begin
                if (one_go || free_go) begin
                    seq_nxt = SQ_REQ;
                    ch_nxt  = 1'b0;
                    one_nxt = one_go;
                    ext_nxt = one_go || (rate_r <= RATE_EXT_MAX);
                    if (free_go) begin
                        rt_nxt = rate_period(rate_r);
                    end
                end
            end
            SQ_REQ: begin
                if (abort) begin
                    seq_nxt = SQ_IDLE;
                end else if (!pend_r) begin
                    // one outstanding request keeps the toggle parity safe
                    rtg_nxt  = !rtg_r;
                    pend_nxt = 1'b1;
                    got_nxt  = 1'b0;
                    req_nxt  = '{remote: ch_r, extended: ext_r, substrate: sens_r};
                    tmr_nxt  = ext_r ? (INTEG_N << 1) - 32'h1 : INTEG_N - 32'h1;
                    seq_nxt  = SQ_WAIT;
                end
            end
            SQ_WAIT: begin
                if (ack_ev) begin
                    got_nxt = 1'b1;
                end
                if (tmr_r != 32'h0) begin
                    tmr_nxt = tmr_r - 32'h1;
                end
                if (abort) begin
                    seq_nxt = SQ_IDLE;
                end else if (tmr_r == 32'h0 && got_r) begin
                    if (!ch_r) begin
                        lnew_nxt = res_r;
                        ch_nxt   = 1'b1;
                        seq_nxt  = SQ_REQ;
                    end else begin
                        loc_nxt = lnew_r;
                        rem_nxt = res_r;
                        seq_nxt = SQ_IDLE;
                    end
                end
            end
            default: seq_nxt = SQ_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            seq_r  <= SQ_IDLE;
            ch_r   <= 1'b0;
            ext_r  <= 1'b0;
            one_r  <= 1'b0;
            got_r  <= 1'b0;
            pend_r <= 1'b0;
            rtg_r  <= 1'b0;
            tmr_r  <= 32'h0;
            rt_r   <= 32'h0;
            res_r  <= '0;
            lnew_r <= '0;
            loc_r  <= '0;
            rem_r  <= '0;
            req_r  <= '0;
            as1_r  <= 1'b0;
            as2_r  <= 1'b0;
            as3_r  <= 1'b0;
        end else begin
            seq_r  <= seq_nxt;
            ch_r   <= ch_nxt;
            ext_r  <= ext_nxt;
            one_r  <= one_nxt;
            got_r  <= got_nxt;
            pend_r <= pend_nxt;
            rtg_r  <= rtg_nxt;
            tmr_r  <= tmr_nxt;
            rt_r   <= rt_nxt;
            res_r  <= res_nxt;
            lnew_r <= lnew_nxt;
            loc_r  <= loc_nxt;
            rem_r  <= rem_nxt;
            req_r  <= req_nxt;
            as1_r  <= lak_r;
            as2_r  <= as1_r;
            as3_r  <= as2_r;
        end
    end

    // ==================================================
    // converter link, adc clock domain
    logic      lr1_r, lr2_r, rq1_r, rq2_r, seen_r, seen_nxt;
    logic      st_r, st_nxt;
    tcc_lnk_t  lk_r, lk_nxt;
    tcc_req_t  lreq_r, lreq_nxt;
    logic [TEMP_W-1:0] ldat_nxt;

    always_ff @(posedge adc_clk_in) begin
        lr1_r <= reset_in;
        lr2_r <= lr1_r;
        rq1_r <= rtg_r;
        rq2_r <= rq1_r;
    end

    // request fields are held stable while the toggle is in flight
    always_comb begin
        lk_nxt   = lk_r;
        seen_nxt = seen_r;
        lak_nxt  = lak_r;
        st_nxt   = 1'b0;
        lreq_nxt = lreq_r;
        ldat_nxt = lnk_dat_r;
        case (lk_r)
            LK_IDLE: begin
                if (rq2_r != seen_r) begin
                    seen_nxt = rq2_r;
                    lreq_nxt = req_r;
                    st_nxt   = 1'b1;
                    lk_nxt   = LK_BUSY;
                end
            end
            LK_BUSY: begin
                if (conv_done_in) begin
                    ldat_nxt = conv_data_in;
                    lak_nxt  = !lak_r;
                    lk_nxt   = LK_IDLE;
                end
            end
            default: lk_nxt = LK_IDLE;
        endcase
    end

    always_ff @(posedge adc_clk_in) begin
        if (lr2_r) begin
            lk_r      <= LK_IDLE;
            seen_r    <= 1'b0;
            lak_r     <= 1'b0;
            st_r      <= 1'b0;
            lreq_r    <= '0;
            lnk_dat_r <= '0;
        end else begin
            lk_r      <= lk_nxt;
            seen_r    <= seen_nxt;
            lak_r     <= lak_nxt;
            st_r      <= st_nxt;
            lreq_r    <= lreq_nxt;
            lnk_dat_r <= ldat_nxt;
        end
    end
    assign conv_start_out = st_r;
    assign conv_req_out   = lreq_r;

    // ==================================================
    // alarms, open drain: drive low when over
    logic al1_r, al2_r;
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            al1_r <= 1'b0;
            al2_r <= 1'b0;
        end else begin
            al1_r <= over_limit(loc_r, lim1_r) || over_limit(rem_r, lim1_r);
            al2_r <= over_limit(loc_r, lim2_r) || over_limit(rem_r, lim2_r);
        end
    end
    assign overtemp_alarm_first_n_out     = 1'b0;
    assign overtemp_alarm_first_n_oe_out  = al1_r;
    assign overtemp_alarm_second_n_out    = 1'b0;
    assign overtemp_alarm_second_n_oe_out = al2_r;
endmodule : tcc_conv_ctrl

// >>> tb/tcc_adc_model.sv
/* converter model on the link clock: answers each start with one done pulse.
   assumes conv_req_in holds from the start pulse until the next one. */
module tcc_adc_model
    import tcc_pkg::*;
(
    // link
    input  wire logic              adc_clk_in,
    input  wire logic              conv_start_in,
    input  wire tcc_req_t          conv_req_in,
    output logic                   conv_done_out,
    output logic [TEMP_W-1:0]      conv_data_out,
    // values to report
    input  wire logic [TEMP_W-1:0] local_val_in,
    input  wire logic [TEMP_W-1:0] remote_val_in
);
    int                wait_cnt = 0;
    logic [TEMP_W-1:0] value;
    initial begin
        conv_done_out = 1'b0;
        conv_data_out = '0;
    end
    // remote answers slowly, local promptly; data toggles when not valid
    always @(posedge adc_clk_in) begin
        value = conv_req_in.remote ? remote_val_in : local_val_in;
        if (!conv_req_in.extended) value[2:0] = 3'h0;
        conv_done_out <= 1'b0;
        conv_data_out <= ~conv_data_out;
        if (conv_start_in) begin
            wait_cnt <= conv_req_in.remote ? 30 : 2;
        end else if (wait_cnt != 0) begin
            wait_cnt <= wait_cnt - 1;
            if (wait_cnt == 1) begin
                conv_done_out <= 1'b1;
                conv_data_out <= value;
            end
        end
    end
endmodule : tcc_adc_model

// >>> tb/tcc_conv_ctrl_monitor.sv
/* port checker of the conversion sequencer, bound into tcc_conv_ctrl.
   assumes the port names and the hand-over timing of the sequencer. */
module tcc_conv_ctrl_monitor
    import tcc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              clock_in,
    input wire logic              reset_in,
    input wire logic              wb_cyc_in,
    input wire logic              wb_stb_in,
    input wire logic              wb_we_in,
    input wire logic [ADDR_W-1:0] wb_adr_in,
    input wire logic [31:0]       wb_dat_out,
    input wire logic              wb_ack_out,
    input wire logic              adc_clk_in,
    input wire logic              conv_start_out,
    input wire tcc_req_t          conv_req_out,
    input wire logic              hw_sleep_n_in,
    input wire logic              overtemp_alarm_first_n_out,
    input wire logic              overtemp_alarm_first_n_oe_out,
    input wire logic              overtemp_alarm_second_n_out
);
    // ==================================================
    // sleep length: the pin passes a 2ff synchroniser first
    logic [3:0] sleep_cnt_r;
    logic [3:0] sleep_cnt_nxt;
    always_comb begin
        sleep_cnt_nxt = sleep_cnt_r;
        if (hw_sleep_n_in) sleep_cnt_nxt = 4'h0;
        else if (sleep_cnt_r != 4'h8) sleep_cnt_nxt = sleep_cnt_r + 4'h1;
    end
    always_ff @(posedge clock_in) begin
        if (reset_in) sleep_cnt_r <= 4'h0;
        else sleep_cnt_r <= sleep_cnt_nxt;
    end
    // ==================================================
    // assertions
    chk_ack_follows: assert property (@(posedge clock_in) disable iff (reset_in)
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
    chk_ack_cause: assert property (@(posedge clock_in) disable iff (reset_in)
        wb_ack_out |-> $past(wb_cyc_in && wb_stb_in && !wb_ack_out)) else $error("stray ack");
    chk_ack_single: assert property (@(posedge clock_in) disable iff (reset_in)
        wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    chk_write_zero: assert property (@(posedge clock_in) disable iff (reset_in)
        wb_ack_out && $past(wb_we_in) |-> wb_dat_out == 32'h0) else $error("write data");
    chk_unmapped_zero: assert property (@(posedge clock_in) disable iff (reset_in)
        wb_ack_out && $past(wb_adr_in) > ADDR_LIMIT2 |-> wb_dat_out == 32'h0)
        else $error("unmapped data");
    chk_upper_zero: assert property (@(posedge clock_in) disable iff (reset_in)
        wb_ack_out |-> wb_dat_out[31:11] == 21'h0) else $error("upper bits set");
    chk_sleep_status: assert property (@(posedge clock_in) disable iff (reset_in)
        wb_ack_out && !$past(wb_we_in) && $past(wb_adr_in) == ADDR_STATUS
        && sleep_cnt_r == 4'h8 |-> wb_dat_out[1:0] == 2'h2) else $error("sleep status");
    chk_alarm_drive: assert property (@(posedge clock_in) disable iff (reset_in)
        !overtemp_alarm_first_n_out && !overtemp_alarm_second_n_out) else $error("alarm level");
    chk_start_pulse: assert property (@(posedge adc_clk_in) disable iff (reset_in)
        conv_start_out |=> !conv_start_out) else $error("start too long");
    chk_req_hold: assert property (@(posedge adc_clk_in) disable iff (reset_in)
        !conv_start_out |-> $stable(conv_req_out)) else $error("request moved");
    cover property (@(posedge adc_clk_in) conv_start_out && conv_req_out.remote);
    cover property (@(posedge clock_in) sleep_cnt_r == 4'h8 && wb_ack_out);
    cover property (@(posedge clock_in) overtemp_alarm_first_n_oe_out);
endmodule : tcc_conv_ctrl_monitor

bind tcc_conv_ctrl tcc_conv_ctrl_monitor #(.ADDR_W(ADDR_W)) i_mon (
    .clock_in(clock_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .adc_clk_in(adc_clk_in),
    .conv_start_out(conv_start_out), .conv_req_out(conv_req_out),
    .hw_sleep_n_in(hw_sleep_n_in),
    .overtemp_alarm_first_n_out(overtemp_alarm_first_n_out),
    .overtemp_alarm_first_n_oe_out(overtemp_alarm_first_n_oe_out),
    .overtemp_alarm_second_n_out(overtemp_alarm_second_n_out));

// >>> tb/tcc_conv_ctrl_tb.sv
/* self-checking bench of the sequencer with the converter model.
   assumes shortened counts: 20 cycles integration, 4096 rate base. */
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module tcc_conv_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tcc_pkg::*;
    typedef struct packed {
        logic [3:0] rate; logic sub; logic [10:0] lv; logic [10:0] rv; logic ext;
    } tcc_row_t;
    logic        clock_in = 0, reset_in = 1, adc_clk = 0, hw_sleep_n = 1;
    logic        wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, conv_start, conv_done, oe1, oe2;
    logic [7:0]  wb_adr = 0;
    logic [3:0]  wb_sel = 0;
    logic [31:0] wb_dat_w = 0, wb_dat_r, q, old;
    logic [10:0] lv = 0, rv = 0, conv_data, e;
    tcc_req_t    req;
    logic        last_ext, last_sub;
    int          failures = 0, compares = 0, rdone = 0, starts = 0, n, s;
    tcc_row_t    rows [5] = '{'{4'h6, 1'b0, 11'h0c5, 11'h1f3, 1'b1},
        '{4'h7, 1'b1, 11'h7a9, 11'h2ee, 1'b0}, '{4'h8, 1'b0, 11'h13f, 11'h6d1, 1'b0},
        '{4'hf, 1'b1, 11'h05b, 11'h1a4, 1'b0}, '{4'h5, 1'b1, 11'h7f7, 11'h00d, 1'b1}};
    always #4 clock_in = ~clock_in;
    initial begin
        #1.3;
        forever #3 adc_clk = ~adc_clk;
    end
    always @(posedge adc_clk) begin
        if (conv_start) begin
            starts++;
            last_ext <= req.extended;
            last_sub <= req.substrate;
        end
        if (conv_done && req.remote) rdone++;
    end
    tcc_conv_ctrl #(.INTEG_CYCLES(20), .RATE_BASE_CYCLES(4096)) i_dut (
        .clock_in(clock_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat_w),
        .wb_dat_out(wb_dat_r), .wb_ack_out(wb_ack), .adc_clk_in(adc_clk),
        .conv_start_out(conv_start), .conv_req_out(req), .conv_done_in(conv_done),
        .conv_data_in(conv_data), .hw_sleep_n_in(hw_sleep_n),
        .overtemp_alarm_first_n_in(!oe1), .overtemp_alarm_first_n_out(),
        .overtemp_alarm_first_n_oe_out(oe1), .overtemp_alarm_second_n_in(!oe2),
        .overtemp_alarm_second_n_out(), .overtemp_alarm_second_n_oe_out(oe2));
    tcc_adc_model i_adc (.adc_clk_in(adc_clk), .conv_start_in(conv_start), .conv_req_in(req),
        .conv_done_out(conv_done), .conv_data_out(conv_data), .local_val_in(lv),
        .remote_val_in(rv));
    // ==================================================
    // bus and wait tasks
    task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d);
        int t = 0;
        @(posedge clock_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= d;
        wb_sel <= 4'hf;
        do begin
            @(posedge clock_in);
            t++;
        end while (wb_ack !== 1'b1 && t < 50);
        q = wb_dat_r;
        if (t >= 50) failures++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb_cycle
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        wb_cycle(a, 1'b0, 32'h0);
        `CHK(nm, x, q)
    endtask : chk_rd
    task automatic poll_busy(input logic v);
        int t = 0;
        do begin
            wb_cycle(ADDR_STATUS, 1'b0, 32'h0);
            t++;
        end while (q[0] !== v && t < 300);
        if (t >= 300) failures++;
    endtask : poll_busy
    task automatic wait_rdone(input int target);
        int t = 0;
        while (rdone < target && t < 20000) begin
            @(posedge clock_in);
            t++;
        end
        if (t >= 20000) failures++;
    endtask : wait_rdone
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #300000;
        failures++;
        give_verdict();
    end
    // ==================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        foreach (rows[i]) begin
            wb_cycle(ADDR_CONFIG, 1'b1, 32'h40);
            wb_cycle(ADDR_RATE, 1'b1, {28'h0, rows[i].rate});
            lv <= rows[i].lv;
            rv <= rows[i].rv;
            n = rdone;
            wb_cycle(ADDR_CONFIG, 1'b1, {26'h0, rows[i].sub, 5'h0});
            wait_rdone(n + 3);
            e = rows[i].ext ? rows[i].lv : {rows[i].lv[10:3], 3'h0};
            chk_rd(ADDR_LOCAL, {21'h0, e}, "local");
            e = rows[i].ext ? rows[i].rv : {rows[i].rv[10:3], 3'h0};
            chk_rd(ADDR_REMOTE, {21'h0, e}, "remote");
            `CHK("extended", rows[i].ext, last_ext)
            `CHK("sensor", rows[i].sub, last_sub)
        end
        // halt, then one shot in legacy rate still runs extended
        wb_cycle(ADDR_CONFIG, 1'b1, 32'h40);
        wb_cycle(ADDR_RATE, 1'b1, 32'h8);
        lv <= 11'h0a8;
        rv <= 11'h0f5;
        repeat (40) @(posedge clock_in);
        s = starts;
        repeat (150) @(posedge clock_in);
        `CHK("halted", s, starts)
        wb_cycle(ADDR_LOCAL, 1'b0, 32'h0);
        old = q;
        wb_cycle(ADDR_ONESHOT, 1'b1, 32'h1);
        poll_busy(1'b1);
        chk_rd(ADDR_LOCAL, old, "held");
        poll_busy(1'b0);
        chk_rd(ADDR_LOCAL, 32'h0a8, "shot local");
        chk_rd(ADDR_REMOTE, 32'h0f5, "shot remote");
        `CHK("shot ext", 1'b1, last_ext)
        chk_rd(ADDR_CONFIG, 32'h40, "config");
        // alarms: 21 and 30 degrees against strict limits
        wb_cycle(ADDR_LIMIT1, 1'b1, 32'h14);
        wb_cycle(ADDR_LIMIT2, 1'b1, 32'h1e);
        repeat (3) @(posedge clock_in);
        `CHK("alarm1", 1'b1, oe1)
        `CHK("alarm2", 1'b0, oe2)
        wb_cycle(ADDR_LIMIT1, 1'b1, 32'h1e);
        wb_cycle(ADDR_LIMIT2, 1'b1, 32'h1d);
        repeat (3) @(posedge clock_in);
        `CHK("alarm1", 1'b0, oe1)
        `CHK("alarm2", 1'b1, oe2)
        // hardware sleep aborts a one shot and blocks the next
        lv <= 11'h333;
        rv <= 11'h444;
        wb_cycle(ADDR_ONESHOT, 1'b1, 32'h1);
        poll_busy(1'b1);
        hw_sleep_n <= 1'b0;
        repeat (12) @(posedge clock_in);
        chk_rd(ADDR_STATUS, 32'h2, "sleep status");
        s = starts;
        wb_cycle(ADDR_ONESHOT, 1'b1, 32'h1);
        repeat (100) @(posedge clock_in);
        `CHK("sleep starts", s, starts)
        chk_rd(ADDR_LOCAL, 32'h0a8, "kept local");
        hw_sleep_n <= 1'b1;
        // second reset and reset values
        reset_in <= 1'b1;
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        chk_rd(ADDR_CONFIG, 32'h0, "config rst");
        chk_rd(ADDR_RATE, 32'h6, "rate rst");
        chk_rd(ADDR_LIMIT1, 32'h55, "limit1 rst");
        chk_rd(ADDR_LOCAL, 32'h0, "local rst");
        chk_rd(8'h20, 32'h0, "unmapped");
        give_verdict();
    end
endmodule : tcc_conv_ctrl_tb
